// >>> logic/sfs_host.sv
// host end: command port, write-data fifo, sck divider and byte shifter
// assumes clk_sys is the only clock here; sck is made from it, mode 0
`timescale 1ns/10ps
`default_nettype none
module sfs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = sfs_pkg::FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [WIDTH-1:0] s_data,
    output logic m_valid,
    input wire logic m_ready,
    output logic [WIDTH-1:0] m_data
);
    localparam int PW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_chk
        $error("sfs_fifo: DEPTH must be a power of two, at least 2");
    end
    logic [WIDTH-1:0] buf_mem [0:DEPTH-1];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic push;
    logic pop;
    logic [PW:0] next_count;

    assign push = s_valid && s_ready;
    assign pop = m_ready && m_valid;
    assign m_valid = count != '0;
    assign m_data = buf_mem[rd_ptr];
    assign next_count = count + (PW+1)'(push) - (PW+1)'(pop);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            s_ready <= 1'b0;
        end else if (ce) begin
            wr_ptr <= wr_ptr + PW'(push);
            rd_ptr <= rd_ptr + PW'(pop);
            count <= next_count;
            // registered ready: full shows one cycle after the last push
            s_ready <= next_count != (PW+1)'(DEPTH);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (ce && push) begin
            buf_mem[wr_ptr] <= s_data;
        end
    end
endmodule

module sfs_host #(
    parameter int SCK_HALF = 4,
    parameter int LEN_W = 16,
    parameter int FIFO_DEPTH = sfs_pkg::FIFO_DEPTH
) (
    sfs_spi_if.host spi,
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_op,
    input wire logic [sfs_pkg::ADDR_BITS-1:0] cmd_addr,
    input wire logic [LEN_W-1:0] cmd_len,
    output logic cmd_ready,
    input wire logic wr_valid,
    input wire logic [7:0] wr_data,
    output logic wr_ready,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic done,
    input wire logic wp_assert
);
    if (SCK_HALF < sfs_pkg::SCK_MIN_HALF || SCK_HALF < sfs_pkg::SYNC_HALF
        || SCK_HALF > 255 || LEN_W < 1 || LEN_W > 24) begin : g_chk
        $error("sfs_host: SCK_HALF must be 3..255, LEN_W 1..24");
    end

    sfs_pkg::sfs_host_state_t state;
    logic [7:0] hc;
    logic [2:0] bit_i;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [7:0] op;
    logic [23:0] addr_sh;
    logic [LEN_W:0] byte_idx;
    logic [LEN_W:0] total;
    logic [2:0] hdr;
    logic miso_s1;
    logic miso_s2;
    logic f_valid;
    logic f_pop;
    logic [7:0] f_data;
    logic half_end;
    logic last_fall;
    logic [LEN_W:0] nidx;
    logic need_fifo;
    logic [7:0] next_byte;
    logic [2:0] next_hdr;

    sfs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .srst(srst),
        .ce(ce),
        .s_valid(wr_valid),
        .s_ready(wr_ready),
        .s_data(wr_data),
        .m_valid(f_valid),
        .m_ready(f_pop),
        .m_data(f_data)
    );

    assign next_hdr = sfs_pkg::sfs_is_mem_op(cmd_op)
                      ? 3'(sfs_pkg::HDR_MEM) + 3'(cmd_op == sfs_pkg::OP_FSTRD)
                      : 3'h1;
    assign half_end = hc == 8'(SCK_HALF - 1);
    assign last_fall = state == sfs_pkg::HS_SHIFT && half_end && spi.sck
                       && bit_i == 3'h7;
    assign nidx = byte_idx + 1'b1;
    assign need_fifo = sfs_pkg::sfs_is_wr_op(op) && nidx >= (LEN_W+1)'(hdr);
    // opcode first, then the address msb byte first, upper bits zero
    assign next_byte = need_fifo ? f_data
                       : (nidx < (LEN_W+1)'(sfs_pkg::HDR_MEM))
                         ? addr_sh[23:16] : 8'h00;
    assign f_pop = need_fifo && f_valid
                   && ((last_fall && nidx != total)
                       || state == sfs_pkg::HS_WAIT);

    // miso comes from another clock's logic, so two flops first
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            miso_s1 <= 1'b1;
            miso_s2 <= 1'b1;
        end else if (ce) begin
            miso_s1 <= spi.miso_line;
            miso_s2 <= miso_s1;
        end
    end

    // open-drain style protect drive; released, the pull-up wins
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            spi.wp_drv <= 1'b0;
            spi.wp_oe <= 1'b0;
        end else if (ce) begin
            spi.wp_drv <= 1'b0;
            spi.wp_oe <= wp_assert;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state <= sfs_pkg::HS_IDLE;
            spi.cs_n <= 1'b1;
            spi.sck <= 1'b0;
            spi.mosi <= 1'b0;
            cmd_ready <= 1'b0;
            rd_valid <= 1'b0;
            rd_data <= 8'h00;
            done <= 1'b0;
            hc <= 8'h00;
            bit_i <= 3'h0;
            tx <= 8'h00;
            rx <= 8'h00;
            op <= 8'h00;
            addr_sh <= 24'h000000;
            byte_idx <= '0;
            total <= '0;
            hdr <= 3'h0;
        end else if (ce) begin
            rd_valid <= 1'b0;
            done <= 1'b0;
            hc <= half_end ? 8'h00 : hc + 8'h01;
            case (state)
                sfs_pkg::HS_IDLE: begin
                    hc <= 8'h00;
                    cmd_ready <= 1'b1;
                    if (cmd_valid && cmd_ready) begin
                        cmd_ready <= 1'b0;
                        op <= cmd_op;
                        addr_sh <= 24'(cmd_addr);
                        hdr <= next_hdr;
                        total <= (LEN_W+1)'(next_hdr) + (LEN_W+1)'(cmd_len);
                        byte_idx <= '0;
                        bit_i <= 3'h0;
                        tx <= cmd_op;
                        spi.mosi <= cmd_op[7];
                        spi.cs_n <= 1'b0; // fresh select per opcode
                        state <= sfs_pkg::HS_LEAD;
                    end
                end
                sfs_pkg::HS_LEAD: begin
                    if (half_end) begin
                        state <= sfs_pkg::HS_SHIFT;
                    end
                end
                sfs_pkg::HS_SHIFT: begin
                    if (half_end) begin
                        spi.sck <= ~spi.sck; // host alone makes sck
                        if (spi.sck) begin
                            rx <= {rx[6:0], miso_s2};
                            spi.mosi <= tx[6];
                            tx <= {tx[6:0], 1'b0};
                            bit_i <= bit_i + 3'h1;
                        end
                    end
                    if (last_fall) begin
                        byte_idx <= nidx;
                        if (sfs_pkg::sfs_is_rd_op(op)
                            && byte_idx >= (LEN_W+1)'(hdr)) begin
                            rd_valid <= 1'b1;
                            rd_data <= {rx[6:0], miso_s2};
                        end
                        if (nidx < (LEN_W+1)'(sfs_pkg::HDR_MEM)) begin
                            addr_sh <= {addr_sh[15:0], 8'h00};
                        end
                        if (nidx == total) begin
                            state <= sfs_pkg::HS_TRAIL;
                        end else if (need_fifo && !f_valid) begin
                            // clock parks low until data arrives
                            state <= sfs_pkg::HS_WAIT;
                        end else begin
                            tx <= next_byte;
                            spi.mosi <= next_byte[7];
                        end
                    end
                end
                sfs_pkg::HS_WAIT: begin
                    hc <= 8'h00;
                    if (f_valid) begin
                        tx <= f_data;
                        spi.mosi <= f_data[7];
                        state <= sfs_pkg::HS_SHIFT;
                    end
                end
                sfs_pkg::HS_TRAIL: begin
                    if (half_end) begin
                        spi.cs_n <= 1'b1; // deselect ends the operation
                        done <= 1'b1;
                        state <= sfs_pkg::HS_GAP;
                    end
                end
                sfs_pkg::HS_GAP: begin
                    if (half_end) begin
                        state <= sfs_pkg::HS_IDLE;
                    end
                end
                default: begin
                    state <= sfs_pkg::HS_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> common/sfs_pkg.sv
// constants, opcodes and state types shared by both ends of the serial link
// assumes a 125 MHz system clock on both sides and one byte-wide memory
package sfs_pkg;
    localparam int ADDR_BITS = 18;
    localparam int ADDR_BYTES = 3;
    localparam int HDR_MEM = 1 + ADDR_BYTES;
    localparam int SYS_MHZ = 125;
    localparam int SCK_MAX_MHZ = 50;
    // least sck half period in system cycles, rounded up
    localparam int SCK_MIN_HALF = (SYS_MHZ + 2 * SCK_MAX_MHZ - 1)
                                  / (2 * SCK_MAX_MHZ);
    // two sync flops plus one cycle of margin before the host samples
    localparam int SYNC_HALF = 3;
    localparam int FIFO_DEPTH = 32;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FSTRD = 8'h0b;
    localparam int SR_PROTECT_BIT = 7;
    localparam int SR_WEL_BIT = 1;
    localparam logic [7:0] SR_RESET = 8'h00;
    localparam logic [7:0] SR_WR_MASK = 8'h8c;

    typedef enum logic [2:0] {
        DS_OPCODE, DS_ADDR, DS_DUMMY, DS_WDATA, DS_RDATA,
        DS_SRWRITE, DS_SRREAD, DS_IGNORE
    } sfs_dev_state_t;

    typedef enum logic [2:0] {
        HS_IDLE, HS_LEAD, HS_SHIFT, HS_WAIT, HS_TRAIL, HS_GAP
    } sfs_host_state_t;

    function automatic logic sfs_is_mem_op(input logic [7:0] op);
        return op == OP_WRITE || op == OP_READ || op == OP_FSTRD;
    endfunction

    function automatic logic sfs_is_wr_op(input logic [7:0] op);
        return op == OP_WRITE || op == OP_WRSR;
    endfunction

    function automatic logic sfs_is_rd_op(input logic [7:0] op);
        return op == OP_READ || op == OP_FSTRD || op == OP_RDSR;
    endfunction
endpackage

// >>> common/sfs_spi_if.sv
// the four-wire serial link plus the protect pin between host and device
// assumes the checker reads the raw miso and miso_oe, the host the resolved lines; pull-ups are modelled here
`timescale 1ns/10ps
`default_nettype none
interface sfs_spi_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic wp_drv;
    logic wp_oe;
    wire logic miso_line;
    wire logic wp_n_line;
    // undriven data line floats; modelled as a high level
    assign miso_line = miso_oe ? miso : 1'b1;
    // weak internal pull-up keeps an open protect pin high
    assign wp_n_line = wp_oe ? wp_drv : 1'b1;
    modport dev(
        input cs_n,
        input sck,
        input mosi,
        input wp_n_line,
        output miso,
        output miso_oe
    );
    modport host(
        output cs_n,
        output sck,
        output mosi,
        output wp_drv,
        output wp_oe,
        input miso_line
    );
endinterface
`default_nettype wire

// >>> logic/sfs_device.sv
// memory end of the serial link: framing, shifting, status and the array
// assumes sck and cs_n come from the host; clk_sys only sees status levels and a write toggle
`timescale 1ns/10ps
`default_nettype none
module sfs_device #(
    parameter int ADDR_BITS = sfs_pkg::ADDR_BITS
) (
    sfs_spi_if.dev spi,
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ce,
    output logic selected,
    output logic mode3,
    output logic byte_written
);
    localparam int DEPTH = 1 << ADDR_BITS;

    if (ADDR_BITS < 9 || ADDR_BITS > 24) begin : g_chk
        $error("sfs_device: ADDR_BITS must lie in 9..24");
    end

    logic [7:0] mem [0:DEPTH-1];
    sfs_pkg::sfs_dev_state_t state;
    logic [2:0] bit_cnt;
    logic [1:0] addr_cnt;
    logic [7:0] rx_sh;
    logic [7:0] opcode;
    logic [ADDR_BITS-1:0] addr;
    logic [7:0] status;
    logic wel;
    logic [7:0] tx_sh;
    logic wp_l1;
    logic wp_l2;
    logic mode3_l;
    logic wr_tog;
    logic [7:0] rx_next;
    logic byte_done;
    logic wr_ok;
    logic [7:0] rd_src;

    // msb enters first, so each new bit lands at the bottom
    assign rx_next = {rx_sh[6:0], spi.mosi};
    assign byte_done = bit_cnt == 3'h7;
    // status writes need the latch and no active hardware protection
    assign wr_ok = wel && !(status[sfs_pkg::SR_PROTECT_BIT] && !wp_l2);

    always_comb begin
        rd_src = mem[addr];
        if (state == sfs_pkg::DS_SRREAD) begin
            rd_src = status;
            rd_src[sfs_pkg::SR_WEL_BIT] = wel;
        end
    end

    // the protect pin is foreign to sck, so two flops first
    always_ff @(posedge spi.sck) begin
        wp_l1 <= spi.wp_n_line;
        wp_l2 <= wp_l1;
    end

    // sck level at the select edge decides mode 0 or mode 3
    always_ff @(negedge spi.cs_n) begin
        mode3_l <= spi.sck;
    end

    // framing: cs_n high holds everything at the opcode start
    // the first rise after select carries opcode bit seven
    always_ff @(posedge spi.sck or posedge spi.cs_n) begin
        if (spi.cs_n) begin
            state <= sfs_pkg::DS_OPCODE;
            bit_cnt <= 3'h0;
            addr_cnt <= 2'h0;
            rx_sh <= 8'h00;
            opcode <= 8'h00;
        end else begin
            rx_sh <= rx_next;
            bit_cnt <= bit_cnt + 3'h1; // inputs taken on the rise
            if (byte_done) begin
                case (state)
                    sfs_pkg::DS_OPCODE: begin
                        opcode <= rx_next; // first byte is the opcode
                        if (rx_next == sfs_pkg::OP_RDSR) begin
                            state <= sfs_pkg::DS_SRREAD;
                        end else if (rx_next == sfs_pkg::OP_WRSR) begin
                            state <= wr_ok ? sfs_pkg::DS_SRWRITE
                                           : sfs_pkg::DS_IGNORE;
                        end else if (sfs_pkg::sfs_is_mem_op(rx_next)) begin
                            state <= sfs_pkg::DS_ADDR;
                        end else begin
                            // unknown or single-byte opcodes end here
                            state <= sfs_pkg::DS_IGNORE;
                        end
                    end
                    sfs_pkg::DS_ADDR: begin
                        addr_cnt <= addr_cnt + 2'h1;
                        if (addr_cnt == 2'(sfs_pkg::ADDR_BYTES - 1)) begin
                            if (opcode == sfs_pkg::OP_FSTRD) begin
                                state <= sfs_pkg::DS_DUMMY;
                            end else if (opcode == sfs_pkg::OP_WRITE) begin
                                state <= sfs_pkg::DS_WDATA;
                            end else begin
                                state <= sfs_pkg::DS_RDATA;
                            end
                        end
                    end
                    sfs_pkg::DS_DUMMY: begin
                        state <= sfs_pkg::DS_RDATA;
                    end
                    sfs_pkg::DS_SRWRITE: begin
                        state <= sfs_pkg::DS_IGNORE;
                    end
                    default: begin
                        state <= state;
                    end
                endcase
            end
        end
    end

    // 24 address bits shift through; only the low ADDR_BITS stay
    always_ff @(posedge spi.sck) begin
        if (!spi.cs_n && byte_done) begin
            if (state == sfs_pkg::DS_ADDR) begin
                addr <= {addr[ADDR_BITS-9:0], rx_next};
            end else if (state == sfs_pkg::DS_WDATA
                         || state == sfs_pkg::DS_RDATA) begin
                addr <= addr + 1'b1;
            end
        end
    end

    // byte goes to the array on its eighth rise, nothing pending
    always_ff @(posedge spi.sck) begin
        if (!spi.cs_n && byte_done && state == sfs_pkg::DS_WDATA && wel) begin
            mem[addr] <= rx_next;
        end
    end

    // sck is parked while srst is high, so only an asynchronous clear
    // reaches this domain; the host keeps sck idle across its release
    always_ff @(posedge spi.sck or posedge srst) begin
        if (srst) begin
            wr_tog <= 1'b0;
        end else if (!spi.cs_n && byte_done && state == sfs_pkg::DS_WDATA
                     && wel) begin
            wr_tog <= ~wr_tog;
        end
    end

    // status and the write latch survive deselect; srst clears both, WRDI or a status write clears the latch
    always_ff @(posedge spi.sck or posedge srst) begin
        if (srst) begin
            status <= sfs_pkg::SR_RESET;
            wel <= 1'b0;
        end else if (!spi.cs_n && byte_done) begin
            if (state == sfs_pkg::DS_OPCODE) begin
                if (rx_next == sfs_pkg::OP_WREN) begin
                    wel <= 1'b1;
                end else if (rx_next == sfs_pkg::OP_WRDI) begin
                    wel <= 1'b0;
                end
            end else if (state == sfs_pkg::DS_SRWRITE) begin
                status <= (status & ~sfs_pkg::SR_WR_MASK)
                          | (rx_next & sfs_pkg::SR_WR_MASK);
                wel <= 1'b0;
            end
        end
    end

    // output changes on the fall and is driven only for read data
    // a byte loads when the bit count has wrapped to zero
    always_ff @(negedge spi.sck or posedge spi.cs_n) begin
        if (spi.cs_n) begin
            spi.miso_oe <= 1'b0;
            spi.miso <= 1'b0;
            tx_sh <= 8'h00;
        end else begin
            spi.miso_oe <= state == sfs_pkg::DS_RDATA
                           || state == sfs_pkg::DS_SRREAD;
            if (bit_cnt == 3'h0) begin
                spi.miso <= rd_src[7];
                tx_sh <= {rd_src[6:0], 1'b0};
            end else begin
                spi.miso <= tx_sh[7];
                tx_sh <= {tx_sh[6:0], 1'b0};
            end
        end
    end

    // sys side: levels through two flops, write events as a toggle
    // no sck edge is needed here, so a paused clock loses nothing
    logic sel_s1;
    logic sel_s2;
    logic m3_s1;
    logic m3_s2;
    logic tog_s1;
    logic tog_s2;
    logic tog_s3;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
            m3_s1 <= 1'b0;
            m3_s2 <= 1'b0;
            tog_s1 <= 1'b0;
            tog_s2 <= 1'b0;
            tog_s3 <= 1'b0;
        end else if (ce) begin
            sel_s1 <= ~spi.cs_n;
            sel_s2 <= sel_s1;
            m3_s1 <= mode3_l;
            m3_s2 <= m3_s1;
            tog_s1 <= wr_tog;
            tog_s2 <= tog_s1;
            tog_s3 <= tog_s2;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            selected <= 1'b0;
            mode3 <= 1'b0;
            byte_written <= 1'b0;
        end else if (ce) begin
            selected <= sel_s2;
            mode3 <= m3_s2;
            byte_written <= tog_s2 ^ tog_s3;
        end
    end
endmodule
`default_nettype wire

// >>> tb/sfs_link_chk.sv
// timing checks on the serial link between the host and memory ends
// assumes every line is sampled by the host's system clock
`timescale 1ns/10ps
`default_nettype none
module sfs_link_chk (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    logic sck_q;
    logic [8:0] rises;
    always_ff @(posedge clk_sys) begin
        sck_q <= sck;
    end
    // rises in this frame; 9 bits hold the longest frame the bench makes
    always_ff @(posedge clk_sys) begin
        if (srst || cs_n) begin
            rises <= 9'h000;
        end else if (sck && !sck_q) begin
            rises <= rises + 9'h001;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    standby_off_a: assert property (cs_n |-> !miso_oe)
        else $error("output driven while deselected");
    oe_on_fall_a: assert property ($rose(miso_oe) |-> !sck && !cs_n)
        else $error("output enabled off a falling clock");
    out_on_fall_a: assert property (!cs_n && $changed(miso) |-> !sck)
        else $error("output bit changed while clock high");
    in_on_rise_a: assert property ($changed(mosi) |-> !sck)
        else $error("input bit changed while clock high");
    idle_clock_a: assert property (cs_n |-> !sck)
        else $error("clock high while deselected");
    lead_time_a: assert property ($fell(cs_n) |-> !sck [*8] ##1 sck)
        else $error("first rise not one sck period after select");
    whole_bytes_a: assert property ($rose(cs_n) |-> rises[2:0] == 3'h0)
        else $error("frame ended inside a byte");
    oe_after_op_a: assert property (miso_oe |-> rises >= 9'h008)
        else $error("output driven during the opcode");
endmodule
`default_nettype wire

// >>> tb/spi_fram_slave_frontend_tb.sv
// bench joining host and memory ends over the serial link interface
// assumes the host makes the serial clock in mode 0 from clk_sys
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module spi_fram_slave_frontend_tb;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic cmd_valid = 1'b0;
    logic [7:0] cmd_op = 8'h00;
    logic [sfs_pkg::ADDR_BITS-1:0] cmd_addr = '0;
    logic [15:0] cmd_len = 16'h0000;
    logic wr_valid = 1'b0;
    logic [7:0] wr_data = 8'h00;
    logic wp_assert = 1'b0;
    logic cmd_ready, wr_ready, rd_valid, done, selected, mode3, byte_written;
    logic [7:0] rd_data;
    logic [7:0] rd_q[$];
    int n_errors = 0;
    int checks_done = 0;
    int n_wr = 0;
    sfs_spi_if spi ();
    sfs_host i_sfs_host (.spi(spi.host), .clk_sys(clk_sys), .srst(srst),
        .ce(1'b1), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_ready(cmd_ready),
        .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
        .rd_valid(rd_valid), .rd_data(rd_data), .done(done),
        .wp_assert(wp_assert));
    sfs_device i_sfs_device (.spi(spi.dev), .clk_sys(clk_sys), .srst(srst),
        .ce(1'b1), .selected(selected), .mode3(mode3),
        .byte_written(byte_written));
    sfs_link_chk i_sfs_link_chk (.clk_sys(clk_sys), .srst(srst),
        .cs_n(spi.cs_n), .sck(spi.sck), .mosi(spi.mosi), .miso(spi.miso),
        .miso_oe(spi.miso_oe));
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    // pulses are sampled mid-cycle, where they have settled
    always @(negedge clk_sys) begin
        if (rd_valid === 1'b1) rd_q.push_back(rd_data);
        if (byte_written === 1'b1) n_wr++;
    end
    task automatic cmd(input logic [7:0] op,
                       input logic [sfs_pkg::ADDR_BITS-1:0] a,
                       input logic [15:0] n);
        @(negedge clk_sys);
        while (cmd_ready !== 1'b1) @(negedge clk_sys);
        cmd_op = op;
        cmd_addr = a;
        cmd_len = n;
        cmd_valid = 1'b1;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        while (done !== 1'b1) @(negedge clk_sys);
    endtask
    // called at a falling edge; leaves valid high for back-to-back pushes
    task automatic push(input logic [7:0] d);
        wr_data = d;
        wr_valid = 1'b1;
        @(posedge clk_sys);
        while (wr_ready !== 1'b1) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic t_mem();
        int i;
        cmd(sfs_pkg::OP_WREN, '0, 16'h0000);
        for (i = 0; i < 32; i++) push(8'(i) ^ 8'h5a);
        wr_valid = 1'b0;
        @(negedge clk_sys);
        `CHK(wr_ready, 1'b0)
        cmd(sfs_pkg::OP_WRITE, 18'h3fff0, 16'h0020);
        rd_q.delete();
        cmd(sfs_pkg::OP_READ, 18'h3fff0, 16'h0020);
        `CHK(n_wr, 32)
        `CHK(rd_q.size(), 32)
        for (i = 0; i < 32; i++) `CHK(rd_q[i], 8'(i) ^ 8'h5a)
        rd_q.delete();
        cmd(sfs_pkg::OP_FSTRD, '0, 16'h0002);
        `CHK(rd_q[0], 8'h4a)
        `CHK(rd_q[1], 8'h4b)
        `CHK(mode3, 1'b0)
    endtask
    // write data held back: the clock pauses mid-frame
    task automatic t_stall();
        cmd(sfs_pkg::OP_WREN, '0, 16'h0000);
        fork
            cmd(sfs_pkg::OP_WRITE, 18'h00100, 16'h0001);
            begin
                repeat (300) @(negedge clk_sys);
                `CHK(selected, 1'b1)
                `CHK(cmd_ready, 1'b0)
                push(8'ha5);
                wr_valid = 1'b0;
            end
        join
        rd_q.delete();
        cmd(sfs_pkg::OP_READ, 18'h00100, 16'h0001);
        `CHK(rd_q[0], 8'ha5)
        `CHK(n_wr, 33)
    endtask
    task automatic wrsr(input logic [7:0] v);
        cmd(sfs_pkg::OP_WREN, '0, 16'h0000);
        push(v);
        wr_valid = 1'b0;
        cmd(sfs_pkg::OP_WRSR, '0, 16'h0001);
        rd_q.delete();
        cmd(sfs_pkg::OP_RDSR, '0, 16'h0001);
    endtask
    task automatic t_status();
        wrsr(8'hff);
        `CHK(rd_q[0], 8'h8c)
        wp_assert = 1'b1;
        wrsr(8'h00);
        `CHK(rd_q[0], 8'h8e)
        wp_assert = 1'b0;
        wrsr(8'h00);
        `CHK(rd_q[0], 8'h00)
        cmd(8'h9f, '0, 16'h0000);
        rd_q.delete();
        cmd(sfs_pkg::OP_RDSR, '0, 16'h0001);
        `CHK(rd_q[0], 8'h00)
    endtask
    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(negedge clk_sys);
        srst = 1'b0;
        t_mem();
        t_stall();
        t_status();
        final_report();
    end
    // whole run needs under 10000 cycles
    initial begin
        repeat (40000) @(posedge clk_sys);
        n_errors++;
        final_report();
    end
endmodule
`default_nettype wire
